// >>> verilog/pwr_pkg.sv
/*
  Shared constants and types for the serial flash power-state control.
  Assumes a single 100 MHz core clock; SPI pins are sampled as synchronous inputs.
*/
`default_nettype none
package pwr_pkg;
  // Core clock period
  localparam int unsigned CLK_PERIOD_NS       = 10;
  // Power-state delays in ns (longest times, so cycle counts round down)
  localparam int unsigned DEEP_ENTRY_DELAY_NS  = 3000;
  localparam int unsigned RESUME_DELAY_NS      = 8000;
  localparam int unsigned ULTRA_ENTRY_DELAY_NS = 3000;
  localparam int unsigned ULTRA_RESUME_DELAY_NS = 30000;
  localparam int unsigned DEEP_ENTRY_CYC   = DEEP_ENTRY_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned RESUME_CYC       = RESUME_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned ULTRA_ENTRY_CYC  = ULTRA_ENTRY_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned ULTRA_RESUME_CYC = ULTRA_RESUME_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W          = 12;

  // Opcodes
  localparam logic [7:0] OP_DEEP_DOWN   = 8'hB9;
  localparam logic [7:0] OP_ULTRA_DOWN  = 8'h79;
  localparam logic [7:0] OP_RESUME      = 8'hAB;
  localparam logic [7:0] OP_RESET_EN    = 8'h66;
  localparam logic [7:0] OP_RESET_GO    = 8'h99;

  // Frame layout: opcode byte, then three dummy bytes, then identifier
  localparam logic [2:0] ID_FIRST_BYTE  = 3'h4;
  localparam logic [2:0] BYTE_CNT_MAX   = 3'h7;
  localparam logic [2:0] BIT_LAST       = 3'h7;

  // Arbitrary neutral identifier value
  localparam logic [7:0] DEVICE_ID_DEFAULT = 8'h5A;

  typedef enum logic [2:0] {
    ST_STANDBY, ST_DEEP_ENTRY, ST_DEEP, ST_RESUME,
    ST_ULTRA_ENTRY, ST_ULTRA, ST_ULTRA_RESET
  } pwr_state_t;

  // Serial pins as seen by the device
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic si;
  } spi_pins_t;

  // Frame progress reported by the receiver
  typedef struct packed {
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_rise;
    logic       active;
    logic [2:0] bit_idx;
    logic [2:0] byte_cnt;
    logic [7:0] opcode;
  } frame_t;
endpackage
`default_nettype wire

// >>> verilog/spi_frame_rx.sv
/*
  Serial frame receiver: detects clock edges, counts bits and bytes,
  captures the first byte as the opcode.
  Assumes pins are already synchronous to clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_frame_rx (
  input  wire logic              clk_in,     // Core clock
  input  wire logic              reset_n_in, // Async reset, active low
  input  wire pwr_pkg::spi_pins_t pins_in,   // Chip select, clock, data in
  output var  pwr_pkg::frame_t    frame_out  // Frame progress
);
  import pwr_pkg::*;

  logic       sclk_q;
  logic       cs_n_q;
  logic [2:0] bit_idx;
  logic [2:0] byte_cnt;
  logic [7:0] shift;
  logic [7:0] opcode;

  // Edge decode against previous sample
  wire sclk_rise = pins_in.sclk & ~sclk_q & ~pins_in.cs_n;
  wire sclk_fall = ~pins_in.sclk & sclk_q & ~pins_in.cs_n;
  wire cs_rise   = pins_in.cs_n & ~cs_n_q;
  wire byte_done = sclk_rise & (bit_idx == BIT_LAST);
  wire [7:0] next_shift = {shift[6:0], pins_in.si};

  // History of the pins
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      sclk_q <= pins_in.sclk;
      cs_n_q <= pins_in.cs_n;
    end
  end

  // Bits arrive MSB first, one per rising clock
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bit_idx  <= 3'h0;
      byte_cnt <= 3'h0;
      shift    <= 8'h00;
      opcode   <= 8'h00;
    end else if (pins_in.cs_n) begin
      bit_idx  <= 3'h0; // Idle: a new frame starts clean
      byte_cnt <= 3'h0;
    end else if (sclk_rise) begin
      bit_idx <= bit_idx + 3'h1;
      shift   <= next_shift;
      if (byte_done && byte_cnt != BYTE_CNT_MAX) begin
        byte_cnt <= byte_cnt + 3'h1; // Saturates; later bytes only repeat
      end
      if (byte_done && byte_cnt == 3'h0) begin
        opcode <= next_shift;
      end
    end
  end

  // Counters are cleared one cycle after the rise, so cs_rise still sees them
  assign frame_out = '{sclk_rise: sclk_rise, sclk_fall: sclk_fall, cs_rise: cs_rise,
                       active: ~pins_in.cs_n, bit_idx: bit_idx, byte_cnt: byte_cnt,
                       opcode: opcode};
endmodule
`default_nettype wire

// >>> verilog/flash_power_ctrl.sv
/*
  Power-state control of a serial flash: deep and ultra sleep entry, resume,
  identifier return and internal reset on ultra exit.
  Assumes SPI pins synchronous to clk_in (sampled fast enough to see each
  serial clock level), and busy and sleep-depth levels from the core.
*/
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Chip select released off a byte boundary abandons the command.
// - Deep power-down opcode ignored while program or erase is busy.
// - Ultra power-down opcode ignored while program or erase is busy.
// - In deep sleep only resume and the reset pair are decoded.
// - Resume in deep sleep leaves it and can return the identifier.
// - Plain resume: release after eighth clock, standby within resume delay.
// - Identifier resume: three dummy bytes then identifier, 40 clocks total.
// - Identifier shifted MSB first, repeated until chip select rises.
// - Resume in ultra sleep leaves it with no identifier.
// - Ultra exit does internal reset, clears SRAM, standby within delay.
// - Ultra entered by ultra opcode or deep opcode with depth bit clear.
// - Ultra sleep ignores every opcode except resume.
// - Ultra entry within entry delay after release; extra bits discarded.
// - Misaligned ultra command returns to standby; reset starts in standby.
// - Opcodes are eight bits, MSB first, one bit per serial clock.
// - Deep opcode with depth bit set enters deep sleep within entry delay.
module flash_power_ctrl #(
  parameter logic [7:0] DEVICE_ID = pwr_pkg::DEVICE_ID_DEFAULT // Arbitrary value
) (
  input  wire logic clk_in,                 // Core clock, 100 MHz
  input  wire logic reset_n_in,             // Async reset, active low
  input  wire logic cs_n_in,                // Chip select, active low
  input  wire logic sclk_in,                // Serial clock
  input  wire logic si_in,                  // Serial data in
  input  wire logic busy_flag_in,           // Program or erase in progress
  input  wire logic sleep_depth_select_in,  // 1: deep, 0: ultra on deep opcode
  output logic      so_out,                 // Serial data out
  output logic      so_oe_out,              // High while driving serial out
  output logic      standby_out,            // Ready for commands
  output logic      deep_sleep_state_out,   // In deep sleep
  output logic      ultra_sleep_state_out,  // In ultra sleep
  output logic      internal_reset_out,     // Core and SRAM reset, level
  output logic      reset_pair_out          // Reset pair decoded, one-cycle pulse
);
  import pwr_pkg::*;

  frame_t           frame;
  pwr_state_t       state;
  pwr_state_t       next_state;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] next_timer;
  logic             reset_armed;
  logic [2:0]       id_bit;

  spi_frame_rx u_rx (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .pins_in    ('{cs_n: cs_n_in, sclk: sclk_in, si: si_in}),
    .frame_out  (frame)
  );

  // Command is valid only when whole bytes were sent
  wire aligned    = frame.cs_rise && frame.bit_idx == 3'h0 && frame.byte_cnt != 3'h0;
  wire is_deep    = frame.opcode == OP_DEEP_DOWN;
  wire is_ultra   = frame.opcode == OP_ULTRA_DOWN;
  wire is_resume  = frame.opcode == OP_RESUME;
  wire is_rst_en  = frame.opcode == OP_RESET_EN && frame.byte_cnt == 3'h1;
  wire is_rst_go  = frame.opcode == OP_RESET_GO && frame.byte_cnt == 3'h1;
  // Power-down refused while busy; the host retries
  wire go_down    = aligned && !busy_flag_in && state == ST_STANDBY;
  wire go_deep    = go_down && is_deep && sleep_depth_select_in;
  wire go_ultra   = go_down && (is_ultra || (is_deep && !sleep_depth_select_in));
  wire timer_done = timer == '0;
  // Identifier phase starts after opcode and dummy bytes
  wire id_phase   = frame.active && frame.byte_cnt >= ID_FIRST_BYTE && is_resume
                    && (state == ST_STANDBY || state == ST_DEEP);

  // Next-state decode
  always_comb begin
    next_state = state;
    next_timer = timer_done ? timer : timer - TIMER_W'(1);
    unique case (state)
      ST_STANDBY: begin
        if (go_deep) begin
          next_state = ST_DEEP_ENTRY;
          next_timer = TIMER_W'(DEEP_ENTRY_CYC);
        end else if (go_ultra) begin
          next_state = ST_ULTRA_ENTRY; // Trailing bytes are not looked at
          next_timer = TIMER_W'(ULTRA_ENTRY_CYC);
        end
      end
      ST_DEEP_ENTRY: if (timer_done) next_state = ST_DEEP;
      ST_DEEP: begin
        // Plain and identifier resume both leave on release
        if (aligned && is_resume) begin
          next_state = ST_RESUME;
          next_timer = TIMER_W'(RESUME_CYC);
        end
      end
      ST_RESUME: if (timer_done) next_state = ST_STANDBY;
      ST_ULTRA_ENTRY: if (timer_done) next_state = ST_ULTRA;
      ST_ULTRA: begin
        // Only resume is heard here, and no identifier follows
        if (aligned && is_resume) begin
          next_state = ST_ULTRA_RESET;
          next_timer = TIMER_W'(ULTRA_RESUME_CYC);
        end
      end
      ST_ULTRA_RESET: if (timer_done) next_state = ST_STANDBY;
      // Unused encoding: fall back to standby rather than lock up
      default: begin
        next_state = ST_STANDBY;
        next_timer = '0;
      end
    endcase
  end

  // State and delay timer; reset lands in standby
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= ST_STANDBY;
      timer <= '0;
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  // Reset pair accepted in deep sleep; pair must be back to back
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reset_armed    <= 1'b0;
      reset_pair_out <= 1'b0;
    end else begin
      reset_pair_out <= 1'b0;
      if (frame.cs_rise) begin
        reset_armed <= 1'b0;
        if (state == ST_DEEP && aligned && is_rst_en) begin
          reset_armed <= 1'b1;
        end
        if (state == ST_DEEP && aligned && is_rst_go && reset_armed) begin
          reset_pair_out <= 1'b1;
        end
      end
    end
  end

  // Identifier out on falling clock, MSB first, wrapping per byte
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      so_out    <= 1'b0;
      so_oe_out <= 1'b0;
      id_bit    <= 3'h0;
    end else if (!id_phase) begin
      so_oe_out <= 1'b0; // Released as soon as chip select rises
      id_bit    <= 3'h0;
    end else if (frame.sclk_fall) begin
      so_oe_out <= 1'b1;
      so_out    <= DEVICE_ID[BIT_LAST - id_bit];
      id_bit    <= id_bit + 3'h1;
    end
  end

  // Registered state flags; internal reset held across the ultra exit
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      standby_out           <= 1'b1;
      deep_sleep_state_out  <= 1'b0;
      ultra_sleep_state_out <= 1'b0;
      internal_reset_out    <= 1'b0;
    end else begin
      standby_out           <= next_state == ST_STANDBY;
      deep_sleep_state_out  <= next_state == ST_DEEP;
      ultra_sleep_state_out <= next_state == ST_ULTRA;
      internal_reset_out    <= next_state == ST_ULTRA_RESET;
    end
  end

  // Checks
  a_busy_blocks_deep: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (aligned && busy_flag_in && state == ST_STANDBY) |=> state == ST_STANDBY)
    else $error("power-down taken while busy");
  a_busy_blocks_ultra: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (aligned && is_ultra && busy_flag_in && state == ST_STANDBY)
    |=> state == ST_STANDBY)
    else $error("ultra entry taken while busy");
  a_misalign_no_act: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (frame.cs_rise && frame.bit_idx != 3'h0 && state == ST_STANDBY)
    |=> state == ST_STANDBY)
    else $error("misaligned command acted on");
  a_deep_entry_time: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    go_deep |-> ##[1:310] state == ST_DEEP)
    else $error("deep sleep not reached in time");
  a_ultra_entry_time: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    go_ultra |-> ##[1:310] state == ST_ULTRA)
    else $error("ultra sleep not reached in time");
  a_depth_select: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (go_down && is_deep && !sleep_depth_select_in) |=> state == ST_ULTRA_ENTRY)
    else $error("deep opcode with depth clear missed ultra");
  a_deep_ignores: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (state == ST_DEEP && aligned && !is_resume) |=> state == ST_DEEP)
    else $error("deep sleep left on foreign opcode");
  a_ultra_ignores: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (state == ST_ULTRA && !(aligned && is_resume)) |=> state == ST_ULTRA)
    else $error("ultra sleep left without resume");
  a_resume_time: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (state == ST_DEEP && aligned && is_resume) |-> ##[1:810] standby_out)
    else $error("deep resume too slow");
  a_ultra_reset: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (state == ST_ULTRA && aligned && is_resume) |-> ##2 internal_reset_out)
    else $error("no internal reset on ultra exit");
  a_ultra_no_id: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state == ST_ULTRA |-> ##1 !so_oe_out)
    else $error("identifier driven in ultra sleep");
  a_id_released: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    frame.cs_rise |=> !so_oe_out)
    else $error("serial out held after release");

  c_deep_cycle: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    state == ST_DEEP ##[1:1000] state == ST_RESUME);
  c_ultra_cycle: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    state == ST_ULTRA ##[1:1000] state == ST_ULTRA_RESET);
  c_id_out: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    so_oe_out && deep_sleep_state_out);
  c_reset_pair: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    reset_pair_out);
endmodule
`default_nettype wire

// >>> dv/spi_host_model.sv
/*
  SPI host model: sends one command frame of n bits and samples serial out.
  Assumes the device samples on rising serial clock and drives on the falling one.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input  wire logic        clk_in,   // Core clock
  output var  logic        cs_n_out, // Chip select, active low
  output var  logic        sclk_out, // Serial clock, idle low
  output var  logic        si_out,   // Serial data to device
  input  wire logic        so_in,    // Serial data from device
  output var  logic [47:0] rx_out    // Bits sampled on rising clock
);
  // Idle pins; the clock stands still outside frames
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    si_out   = 1'b0;
    rx_out   = '0;
  end

  // Bits taken from the top of the vector; an n that is not a multiple of eight gives a misaligned frame
  task automatic frame(input logic [47:0] bits, input int n);
    int i;
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    repeat (2) @(posedge clk_in);
    for (i = 0; i < n; i++) begin
      si_out   <= bits[47-i]; // MSB first, one bit a clock
      sclk_out <= 1'b0;
      repeat (3) @(posedge clk_in);
      sclk_out <= 1'b1;
      rx_out   <= {rx_out[46:0], so_in}; // Value launched on the previous fall
      repeat (3) @(posedge clk_in);
    end
    sclk_out <= 1'b0;
    repeat (3) @(posedge clk_in);
    cs_n_out <= 1'b1;
    si_out   <= ~si_out; // Released line must not keep its last value
    repeat (4) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// >>> dv/flash_power_ctrl_tb.sv
/*
  Self-checking bench for the flash power-state control.
  Assumes 100 MHz clock and the entry and resume counts of the package.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_power_ctrl_tb;
  import pwr_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, busy = 1'b0, depth = 1'b1;
  logic cs_n, sclk, si, so, so_oe, standby, deep, ultra, irst, pair;
  logic [47:0] rx;
  logic [2:0]  st;
  int num_errors = 0, comparisons = 0, pair_cnt = 0, oe_cnt = 0;
  localparam logic [2:0] SB = 3'h4, DP = 3'h2, UL = 3'h1;
  assign st = {standby, deep, ultra};

  always #5 clk = ~clk;

  // Event counters; a one-cycle pulse is easy to miss from a task
  always @(posedge clk) begin
    if (pair === 1'b1) pair_cnt++;
    if (so_oe === 1'b1) oe_cnt++;
  end

  flash_power_ctrl u_flash_power_ctrl (
    .clk_in(clk), .reset_n_in(reset_n), .cs_n_in(cs_n), .sclk_in(sclk), .si_in(si),
    .busy_flag_in(busy), .sleep_depth_select_in(depth), .so_out(so), .so_oe_out(so_oe),
    .standby_out(standby), .deep_sleep_state_out(deep), .ultra_sleep_state_out(ultra),
    .internal_reset_out(irst), .reset_pair_out(pair));

  spi_host_model u_spi_host_model (
    .clk_in(clk), .cs_n_out(cs_n), .sclk_out(sclk), .si_out(si), .so_in(so), .rx_out(rx));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic op(input logic [7:0] code, input int n);
    u_spi_host_model.frame({code, 40'h0}, n);
  endtask

  // Bounded wait for a power state, sampled away from the clock edge
  task automatic wait_st(input logic [2:0] exp, input int lim);
    int i;
    for (i = 0; i < lim && st !== exp; i++) @(negedge clk);
    chk({13'h0, st}, {13'h0, exp});
  endtask

  task automatic idle_chk(input logic [2:0] exp);
    repeat (400) @(negedge clk);
    chk({13'h0, st}, {13'h0, exp});
  endtask

  task automatic t_reset_vals();
    @(negedge clk);
    chk({10'h0, standby, deep, ultra, irst, so_oe, pair}, 16'h0020);
  endtask

  task automatic t_deep_cmds();
    int p;
    op(OP_DEEP_DOWN, 8);
    wait_st(DP, 320);
    op(OP_ULTRA_DOWN, 8);
    op(OP_DEEP_DOWN, 8);
    idle_chk(DP);
    op(OP_RESUME, 7);
    repeat (500) @(negedge clk);
    idle_chk(DP);
    p = pair_cnt;
    op(OP_RESET_EN, 8);
    op(OP_RESET_GO, 8);
    chk(16'(pair_cnt - p), 16'h0001);
    op(OP_RESUME, 48);
    chk(rx[15:0], {DEVICE_ID_DEFAULT, DEVICE_ID_DEFAULT});
    chk({15'h0, so_oe}, 16'h0000);
    wait_st(SB, 820);
  endtask

  task automatic t_deep_plain();
    op(OP_DEEP_DOWN, 8);
    wait_st(DP, 320);
    op(OP_RESUME, 8);
    wait_st(SB, 820);
  endtask

  task automatic t_busy();
    @(posedge clk) busy <= 1'b1;
    op(OP_DEEP_DOWN, 8);
    op(OP_ULTRA_DOWN, 8);
    idle_chk(SB);
    @(posedge clk) busy <= 1'b0;
    u_spi_host_model.frame({OP_ULTRA_DOWN, 8'hFF, 32'h0}, 16);
    wait_st(UL, 320);
  endtask

  task automatic t_ultra_exit();
    int o, i;
    o = oe_cnt;
    op(OP_DEEP_DOWN, 8);
    op(OP_RESET_EN, 8);
    idle_chk(UL);
    op(OP_RESUME, 8);
    for (i = 0; i < 10 && irst !== 1'b1 && standby !== 1'b1; i++) @(negedge clk);
    chk({15'h0, irst}, 16'h0001);
    wait_st(SB, 3020);
    @(negedge clk);
    chk({15'h0, irst}, 16'h0000);
    chk(16'(oe_cnt - o), 16'h0000);
  endtask

  task automatic t_depth_clear();
    @(posedge clk) depth <= 1'b0;
    op(OP_DEEP_DOWN, 8);
    wait_st(UL, 320);
    op(OP_RESUME, 8);
    wait_st(SB, 3020);
    @(posedge clk) depth <= 1'b1;
  endtask

  task automatic t_misaligned();
    op(OP_ULTRA_DOWN, 12);
    idle_chk(SB);
  endtask

  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Whole run is near 12600 cycles; the watchdog allows about six times that
  initial begin
    repeat (80000) @(posedge clk);
    num_errors++;
    close_out();
  end

  initial begin
    repeat (3) @(posedge clk);
    t_reset_vals();
    @(posedge clk) reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset_vals();
    t_deep_cmds();
    t_deep_plain();
    t_busy();
    t_ultra_exit();
    t_depth_clear();
    t_misaligned();
    close_out();
  end
endmodule
`default_nettype wire
